// ### pemr_pkg.sv
// Package for the protection event mask reporter: constants and types.
// Assumes both ends, the checker and the testbench import it.
package pemr_pkg;
   // ****************************************
   // Event codes
   // ****************************************
   localparam logic [5:0] EV_OC_BASE      = 6'h01;
   localparam logic [5:0] EV_EF_BASE      = 6'h09;
   localparam logic [5:0] EV_OUT_BASE     = 6'h11;
   localparam logic [5:0] EV_RESTART      = 6'h32;
   localparam logic [5:0] EV_OVERFLOW     = 6'h33;
   localparam logic [5:0] EV_LINK_BREAK   = 6'h34;
   localparam logic [5:0] EV_NO_RESPONSE  = 6'h35;
   localparam logic [5:0] EV_RESPONDS     = 6'h36;
   // ****************************************
   // Mask reset values
   // ****************************************
   localparam logic [7:0] OC_MASK_RST     = 8'h55;
   localparam logic [7:0] EF_MASK_RST     = 8'h55;
   localparam logic [9:0] OUT_MASK_RST    = 10'h300;
   // ****************************************
   // Data items on channel 0
   // ****************************************
   localparam logic [3:0] CHANNEL_DATA    = 4'h0;
   localparam logic [7:0] ITEM_OC_MASK    = 8'h00;
   localparam logic [7:0] ITEM_EF_MASK    = 8'h01;
   localparam logic [7:0] ITEM_OUT_MASK   = 8'h02;
   localparam logic [7:0] ITEM_INPUTS     = 8'h03;
   localparam logic [7:0] ITEM_STAGES     = 8'h04;
   localparam logic [7:0] ITEM_OUTPUTS    = 8'h05;
   localparam logic [7:0] ITEM_MEMORY     = 8'h06;
   localparam logic [7:0] ITEM_PASSWORD   = 8'h07;
   localparam logic [15:0] PASSWORD_VALUE = 16'h1234; // arbitrary
   // ****************************************
   // Queue and controller registers
   // ****************************************
   localparam int          QUEUE_DEPTH    = 16;
   localparam int          QUEUE_AW       = 4;
   localparam logic [3:0]  CTL_CMD        = 4'h0;
   localparam logic [3:0]  CTL_WDATA      = 4'h1;
   localparam logic [3:0]  CTL_RDATA      = 4'h2;
   localparam logic [3:0]  CTL_EVENT      = 4'h3;
   localparam logic [3:0]  CTL_STATUS     = 4'h4;
   localparam logic [3:0]  CTL_IRQ_CLR    = 4'h5;
   localparam logic [3:0]  CTL_IRQ_EN     = 4'h6;
   localparam logic [3:0]  CTL_LINK      = 4'h7;
   localparam int          IRQ_EVENT      = 0;
   localparam int          IRQ_READ_DONE  = 1;
   localparam int          IRQ_REFUSED    = 2;
   localparam int          IRQ_LINK       = 3;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_REQ  = 2'b01,
      HS_WAIT = 2'b11
   } pemr_host_state_e;
endpackage : pemr_pkg

// ### pemr_link_if.sv
// Link between the relay module and the communication unit.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface pemr_link_if;
   logic        req;      // Unit request strobe
   logic        wr;       // Request is a write
   logic [3:0]  channel;
   logic [7:0]  item;
   logic [15:0] wdata;
   logic        ack;      // Module answer strobe
   logic        refused;
   logic [15:0] rdata;
   logic        ev_valid; // Event record offered
   logic [5:0]  ev_code;
   logic        ev_take;  // Unit collects event
   modport relay (input req, wr, channel, item, wdata, ev_take,
                  output ack, refused, rdata, ev_valid, ev_code);
   modport unit  (output req, wr, channel, item, wdata, ev_take,
                  input ack, refused, rdata, ev_valid, ev_code);
endinterface : pemr_link_if

// ### pemr_relay.sv
// Relay module end: event masking, event queue and data item access.
// Assumes the communication unit side of pemr_link_if on the same clock.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
module pemr_relay
   import pemr_pkg::*;
(
   // Clock and reset
   input  wire logic       MCLK_I,
   input  wire logic       RESET_I,
   // Protection stage levels: start/operate for four stages
   input  wire logic [3:0] STAGE_START_I,
   input  wire logic [3:0] STAGE_OPERATE_I,
   // Measured input values
   input  wire logic [15:0] INPUT_VALUE_I,
   // Output signal levels from the relay logic
   input  wire logic [4:0] OUT_SIGNAL_I,
   // Commanded output signal levels
   output logic      [4:0] OUT_FORCE_O,
   // Link
   pemr_link_if.relay      link
);
   // ****************************************
   // Event detection
   // ****************************************
   logic [7:0]  oc_mask_reg, oc_mask_next;
   logic [7:0]  ef_mask_reg, ef_mask_next;
   logic [9:0]  out_mask_reg, out_mask_next;
   logic [3:0]  start_reg, oper_reg;
   logic [4:0]  out_reg;
   logic [7:0]  oc_raw, ef_raw;
   logic [9:0]  out_raw;
   logic [25:0] ev_hit;
   logic        restart_reg, restart_next;
   logic        ovf_pend_reg, ovf_pend_next;

   // Edge events per stage: start, reset-start, operate, reset-operate
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_stage
         assign oc_raw[4*g+0] = STAGE_START_I[g] & ~start_reg[g];
         assign oc_raw[4*g+1] = ~STAGE_START_I[g] & start_reg[g];
         assign oc_raw[4*g+2] = STAGE_OPERATE_I[g] & ~oper_reg[g];
         assign oc_raw[4*g+3] = ~STAGE_OPERATE_I[g] & oper_reg[g];
         assign ef_raw[4*g+0] = STAGE_START_I[g+2] & ~start_reg[g+2];
         assign ef_raw[4*g+1] = ~STAGE_START_I[g+2] & start_reg[g+2];
         assign ef_raw[4*g+2] = STAGE_OPERATE_I[g+2] & ~oper_reg[g+2];
         assign ef_raw[4*g+3] = ~STAGE_OPERATE_I[g+2] & oper_reg[g+2];
      end
      for (g = 0; g < 5; g++) begin : g_out
         assign out_raw[2*g]   = OUT_SIGNAL_I[g] & ~out_reg[g];
         assign out_raw[2*g+1] = ~OUT_SIGNAL_I[g] & out_reg[g];
      end
   endgenerate
   // Masks applied at detection; dropped events never stored
   assign ev_hit = {out_raw & out_mask_reg,
                    ef_raw & ef_mask_reg,
                    oc_raw & oc_mask_reg};

   // ****************************************
   // Event queue
   // ****************************************
   logic [5:0]          queue_mem [QUEUE_DEPTH];
   logic [QUEUE_AW:0]   wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic                push;
   logic [5:0]          push_code;
   logic                full;
   logic                empty;

   assign full  = (wr_ptr_reg[QUEUE_AW] != rd_ptr_reg[QUEUE_AW]) &&
                  (wr_ptr_reg[QUEUE_AW-1:0] == rd_ptr_reg[QUEUE_AW-1:0]);
   assign empty = (wr_ptr_reg == rd_ptr_reg);

   // One record per cycle; lowest code wins, others of the same cycle are lost,
   // accepted since a simultaneous burst is rare. System events go first.
   always_comb begin
      push      = 1'b0;
      push_code = '0;
      if (restart_reg) begin
         push      = 1'b1;
         push_code = EV_RESTART;
      end else if (ovf_pend_reg) begin
         push      = 1'b1;
         push_code = EV_OVERFLOW;
      end else begin
         for (int i = 25; i >= 0; i--) begin
            if (ev_hit[i]) begin
               push      = 1'b1;
               push_code = 6'(i + 1);
            end
         end
      end
   end

   always_comb begin
      restart_next  = 1'b0;
      ovf_pend_next = ovf_pend_reg;
      wr_ptr_next   = wr_ptr_reg;
      rd_ptr_next   = rd_ptr_reg;
      if (link.ev_take && !empty) begin
         rd_ptr_next = rd_ptr_reg + 1'b1;
      end
      if (push && restart_reg) begin
         wr_ptr_next = wr_ptr_reg + 1'b1;
      end else if (push && ovf_pend_reg) begin
         if (!full) begin
            wr_ptr_next   = wr_ptr_reg + 1'b1;
            ovf_pend_next = 1'b0;
         end
      end else if (push) begin
         if (full) begin
            ovf_pend_next = 1'b1;
         end else begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
         end
      end
      if (full && !(link.ev_take && !empty)) begin
         wr_ptr_next = wr_ptr_reg;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (wr_ptr_next != wr_ptr_reg) begin
         queue_mem[wr_ptr_reg[QUEUE_AW-1:0]] <= push_code;
      end
   end

   // Spontaneous offer whenever queue holds a record
   assign link.ev_valid = !empty;
   assign link.ev_code  = queue_mem[rd_ptr_reg[QUEUE_AW-1:0]];

   // ****************************************
   // Data item access
   // ****************************************
   logic        ack_reg, ack_next;
   logic        ref_reg, ref_next;
   logic [15:0] rdata_reg, rdata_next;
   logic        pw_ok_reg, pw_ok_next;
   logic [4:0]  force_reg, force_next;
   logic [7:0]  memory_reg, memory_next;

   always_comb begin
      ack_next      = 1'b0;
      ref_next      = 1'b0;
      rdata_next    = rdata_reg;
      pw_ok_next    = pw_ok_reg;
      force_next    = force_reg;
      oc_mask_next  = oc_mask_reg;
      ef_mask_next  = ef_mask_reg;
      out_mask_next = out_mask_reg;
      memory_next   = memory_reg | {oper_reg, start_reg};
      if (link.req) begin
         ack_next = 1'b1;
         if (link.channel != CHANNEL_DATA) begin
            ref_next = 1'b1;
         end else if (!link.wr) begin
            unique case (link.item)
               ITEM_OC_MASK:  rdata_next = {8'h00, oc_mask_reg};
               ITEM_EF_MASK:  rdata_next = {8'h00, ef_mask_reg};
               ITEM_OUT_MASK: rdata_next = {6'h00, out_mask_reg};
               ITEM_INPUTS:   rdata_next = INPUT_VALUE_I;
               ITEM_STAGES:   rdata_next = {8'h00, oper_reg, start_reg};
               ITEM_OUTPUTS:  rdata_next = {11'h000, out_reg};
               ITEM_MEMORY:   rdata_next = {8'h00, memory_reg};
               default: begin
                  rdata_next = '0;
                  ref_next   = 1'b1;
               end
            endcase
         end else begin
            unique case (link.item)
               ITEM_OC_MASK:  oc_mask_next  = link.wdata[7:0];
               ITEM_EF_MASK:  ef_mask_next  = link.wdata[7:0];
               ITEM_OUT_MASK: out_mask_next = link.wdata[9:0];
               ITEM_PASSWORD: pw_ok_next = (link.wdata == PASSWORD_VALUE);
               ITEM_OUTPUTS: begin
                  if (pw_ok_reg) begin
                     force_next = link.wdata[4:0];
                  end else begin
                     ref_next = 1'b1;
                  end
               end
               ITEM_MEMORY: begin
                  if (pw_ok_reg) begin
                     memory_next = '0;
                  end else begin
                     ref_next = 1'b1;
                  end
               end
               default: ref_next = 1'b1;
            endcase
         end
      end
   end

   assign link.ack     = ack_reg;
   assign link.refused = ref_reg;
   assign link.rdata   = rdata_reg;
   assign OUT_FORCE_O  = force_reg;

   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         oc_mask_reg  <= OC_MASK_RST;
         ef_mask_reg  <= EF_MASK_RST;
         out_mask_reg <= OUT_MASK_RST;
         start_reg    <= '0;
         oper_reg     <= '0;
         out_reg      <= '0;
         restart_reg  <= 1'b1;
         ovf_pend_reg <= 1'b0;
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         ack_reg      <= 1'b0;
         ref_reg      <= 1'b0;
         rdata_reg    <= '0;
         pw_ok_reg    <= 1'b0;
         force_reg    <= '0;
         memory_reg   <= '0;
      end else begin
         oc_mask_reg  <= oc_mask_next;
         ef_mask_reg  <= ef_mask_next;
         out_mask_reg <= out_mask_next;
         start_reg    <= STAGE_START_I;
         oper_reg     <= STAGE_OPERATE_I;
         out_reg      <= OUT_SIGNAL_I;
         restart_reg  <= restart_next;
         ovf_pend_reg <= ovf_pend_next;
         wr_ptr_reg   <= wr_ptr_next;
         rd_ptr_reg   <= rd_ptr_next;
         ack_reg      <= ack_next;
         ref_reg      <= ref_next;
         rdata_reg    <= rdata_next;
         pw_ok_reg    <= pw_ok_next;
         force_reg    <= force_next;
         memory_reg   <= memory_next;
      end
   end
endmodule : pemr_relay

// ### pemr_unit.sv
// Communication unit end: collects events, issues item requests.
// Assumes the relay side of pemr_link_if on the same clock.
`timescale 1ns/100ps
module pemr_unit
   import pemr_pkg::*;
(
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RESET_I,
   // Software port
   input  wire logic [3:0]  ADDR_I,
   input  wire logic [31:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic      [31:0] RDATA_O,
   output logic             IRQ_O,
   // Link
   pemr_link_if.unit        link
);
   // ****************************************
   // Registers
   // ****************************************
   pemr_host_state_e st_reg, st_next;
   logic [12:0] cmd_reg, cmd_next;    // {wr, channel, item}
   logic [15:0] wd_reg, wd_next;
   logic [15:0] rd_reg, rd_next;
   logic [5:0]  ev_reg, ev_next;
   logic        evv_reg, evv_next;
   logic [3:0]  sts_reg, sts_next, en_reg, en_next;
   logic        link_up_reg, link_up_next;
   logic [31:0] rdo_reg, rdo_next;
   logic        take;
   logic        timeout;
   logic [7:0]  wait_reg, wait_next;

   assign take    = link.ev_valid && !evv_reg;
   assign timeout = (wait_reg == 8'hff);

   always_comb begin
      st_next      = st_reg;
      cmd_next     = cmd_reg;
      wd_next      = wd_reg;
      rd_next      = rd_reg;
      ev_next      = ev_reg;
      evv_next     = evv_reg;
      en_next      = en_reg;
      link_up_next = link_up_reg;
      wait_next    = wait_reg;
      sts_next     = sts_reg;
      rdo_next     = '0;
      if (WR_I) begin
         unique case (ADDR_I)
            CTL_CMD: begin
               cmd_next = WDATA_I[12:0];
               if (st_reg == HS_IDLE) begin
                  st_next = HS_REQ;
               end
            end
            CTL_WDATA:   wd_next  = WDATA_I[15:0];
            CTL_IRQ_CLR: sts_next = sts_reg & ~WDATA_I[3:0];
            CTL_IRQ_EN:  en_next  = WDATA_I[3:0];
            default: ;
         endcase
      end
      if (RD_I) begin
         unique case (ADDR_I)
            CTL_RDATA:  rdo_next = {16'h0000, rd_reg};
            CTL_EVENT: begin
               rdo_next = {25'h0, evv_reg, ev_reg};
               evv_next = 1'b0;
            end
            CTL_STATUS: rdo_next = {28'h0, sts_reg};
            CTL_IRQ_EN: rdo_next = {28'h0, en_reg};
            CTL_LINK:   rdo_next = {30'h0, link_up_reg, st_reg != HS_IDLE};
            default:    rdo_next = '0;
         endcase
      end
      unique case (st_reg)
         HS_IDLE: wait_next = '0;
         HS_REQ:  st_next = HS_WAIT;
         HS_WAIT: begin
            wait_next = wait_reg + 8'h01;
            if (link.ack) begin
               st_next      = HS_IDLE;
               rd_next      = link.rdata;
               sts_next[IRQ_READ_DONE] = 1'b1;
               if (link.refused) begin
                  sts_next[IRQ_REFUSED] = 1'b1;
               end
               if (!link_up_reg) begin
                  // Module answers again
                  link_up_next = 1'b1;
                  ev_next  = EV_RESPONDS;
                  evv_next = 1'b1;
                  sts_next[IRQ_LINK] = 1'b1;
               end
            end else if (timeout) begin
               // No answer: report loss of the module
               st_next      = HS_IDLE;
               link_up_next = 1'b0;
               ev_next  = link_up_reg ? EV_NO_RESPONSE : EV_LINK_BREAK;
               evv_next = 1'b1;
               sts_next[IRQ_LINK] = 1'b1;
            end
         end
         default: st_next = HS_IDLE;
      endcase
      if (take) begin
         ev_next  = link.ev_code;
         evv_next = 1'b1;
         sts_next[IRQ_EVENT] = 1'b1;
      end
   end

   assign link.req     = (st_reg == HS_REQ);
   assign link.wr      = cmd_reg[12];
   assign link.channel = cmd_reg[11:8];
   assign link.item    = cmd_reg[7:0];
   assign link.wdata   = wd_reg;
   assign link.ev_take = take;
   assign RDATA_O      = rdo_reg;
   assign IRQ_O        = |(sts_reg & en_reg);

   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         st_reg      <= HS_IDLE;
         cmd_reg     <= '0;
         wd_reg      <= '0;
         rd_reg      <= '0;
         ev_reg      <= '0;
         evv_reg     <= 1'b0;
         sts_reg     <= '0;
         en_reg      <= '0;
         link_up_reg <= 1'b1;
         wait_reg    <= '0;
         rdo_reg     <= '0;
      end else begin
         st_reg      <= st_next;
         cmd_reg     <= cmd_next;
         wd_reg      <= wd_next;
         rd_reg      <= rd_next;
         ev_reg      <= ev_next;
         evv_reg     <= evv_next;
         sts_reg     <= sts_next;
         en_reg      <= en_next;
         link_up_reg <= link_up_next;
         wait_reg    <= wait_next;
         rdo_reg     <= rdo_next;
      end
   end
endmodule : pemr_unit

// ### pemr_chk.sv
// Checker for the link between relay module and communication unit.
// Assumes the link signals are handed in plainly, beside the interface.
`timescale 1ns/100ps
module pemr_chk
   import pemr_pkg::*;
(
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RESET_I,
   // Unit side
   input  wire logic        req,
   input  wire logic        wr,
   input  wire logic [3:0]  channel,
   input  wire logic [7:0]  item,
   input  wire logic [15:0] wdata,
   input  wire logic        ev_take,
   // Relay side
   input  wire logic        ack,
   input  wire logic        refused,
   input  wire logic [15:0] rdata,
   input  wire logic        ev_valid,
   input  wire logic [5:0]  ev_code
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);
   // ****************************************
   // Sequences
   // ****************************************
   sequence s_answer;
      ack ##1 !ack;
   endsequence
   sequence s_restart;
      ##[1:2] (ev_valid && ev_code == EV_RESTART);
   endsequence
   // ****************************************
   // Properties
   // ****************************************
   property p_ack_next; req |=> s_answer; endproperty
   property p_ack_cause; ack |-> $past(req); endproperty
   property p_bad_channel; req && channel != CHANNEL_DATA |=> refused;
   endproperty
   property p_bad_item; req && item > ITEM_PASSWORD |=> refused; endproperty
   property p_mask_write;
      req && wr && channel == CHANNEL_DATA && item <= ITEM_OUT_MASK
      |=> ack && !refused;
   endproperty
   property p_refuse_cause; refused |-> $past(req); endproperty
   property p_restart; $fell(RESET_I) |-> s_restart; endproperty
   property p_head_hold;
      ev_valid && !ev_take |=> ev_valid && $stable(ev_code);
   endproperty
   property p_rdata_hold; !(req && !wr) |=> $stable(rdata); endproperty
   property p_take_valid; ev_take |-> ev_valid; endproperty
   // ****************************************
   // Assertions
   // ****************************************
   a_ack_next: assert property (p_ack_next)
      else $error("ack not one cycle after request");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_bad_channel: assert property (p_bad_channel)
      else $error("request off channel zero not refused");
   a_bad_item: assert property (p_bad_item)
      else $error("unknown item not refused");
   a_mask_write: assert property (p_mask_write)
      else $error("mask write refused");
   a_refuse_cause: assert property (p_refuse_cause)
      else $error("refusal without request");
   a_restart: assert property (p_restart)
      else $error("no restart record after reset");
   a_head_hold: assert property (p_head_hold)
      else $error("event head lost before collection");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
   a_take_valid: assert property (p_take_valid)
      else $error("event taken while none offered");
endmodule : pemr_chk

// ### test_protection_event_mask_reporter.sv
// Testbench: relay module and communication unit joined by the link.
// Assumes software reaches the unit registers only through its port.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
   begin tests_run++; if ((got) !== (exp)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module test_protection_event_mask_reporter
   import pemr_pkg::*;
;
   logic        mclk, reset, wr_s, rd_s, irq;
   logic [3:0]  stage_start, stage_operate, addr;
   logic [15:0] input_value;
   logic [4:0]  out_signal, out_force;
   logic [31:0] wdata, rdata, st, rd;
   int          errors, tests_run;
   pemr_link_if link();
   pemr_relay u_pemr_relay(.MCLK_I(mclk), .RESET_I(reset),
      .STAGE_START_I(stage_start), .STAGE_OPERATE_I(stage_operate),
      .INPUT_VALUE_I(input_value), .OUT_SIGNAL_I(out_signal),
      .OUT_FORCE_O(out_force), .link(link));
   pemr_unit u_pemr_unit(.MCLK_I(mclk), .RESET_I(reset), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
      .IRQ_O(irq), .link(link));
   pemr_chk u_pemr_chk(.MCLK_I(mclk), .RESET_I(reset), .req(link.req),
      .wr(link.wr), .channel(link.channel), .item(link.item),
      .wdata(link.wdata), .ev_take(link.ev_take), .ack(link.ack),
      .refused(link.refused), .rdata(link.rdata),
      .ev_valid(link.ev_valid), .ev_code(link.ev_code));
   // ****************************************
   // Bus and link tasks
   // ****************************************
   task sw_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk); addr <= a; wdata <= d; wr_s <= 1'b1;
      @(posedge mclk); wr_s <= 1'b0;
   endtask : sw_wr
   task sw_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk); addr <= a; rd_s <= 1'b1;
      @(posedge mclk); rd_s <= 1'b0;
      @(negedge mclk); d = rdata;
   endtask : sw_rd
   // Polls status; clears done and refused so the next poll starts clean
   task link_op(input logic w, input logic [3:0] ch, input logic [7:0] it,
                input logic [15:0] wd);
      int n;
      sw_wr(CTL_WDATA, {16'h0000, wd});
      sw_wr(CTL_CMD, {19'h00000, w, ch, it});
      st = '0;
      n = 0;
      while (st[2:1] == 2'b00 && n < 20) begin
         sw_rd(CTL_STATUS, st);
         n++;
      end
      sw_rd(CTL_RDATA, rd);
      sw_wr(CTL_IRQ_CLR, 32'h00000006);
   endtask : link_op
   // Expects one record, or none when the valid bit of exp is low
   task ev_chk(input logic [6:0] exp);
      logic [31:0] e;
      int          n;
      e = '0;
      n = 0;
      while (e[6] !== 1'b1 && n < 10) begin
         sw_rd(CTL_EVENT, e);
         n++;
      end
      `CHK("event", exp, exp[6] ? e[6:0] : {e[6], 6'h00})
   endtask : ev_chk
   task step(input logic [3:0] s, input logic [3:0] o,
             input logic [4:0] q, input logic [6:0] exp);
      @(posedge mclk);
      stage_start <= s; stage_operate <= o; out_signal <= q;
      ev_chk(exp);
   endtask : step
   // ****************************************
   // Scenarios
   // ****************************************
   task t_restart;
      // Restart record needs two edges to reach the status bit
      repeat (2) @(posedge mclk);
      sw_rd(CTL_STATUS, st);
      `CHK("restart_status", 1'b1, st[IRQ_EVENT])
      `CHK("irq_disabled", 1'b0, irq)
      sw_wr(CTL_IRQ_EN, 32'h00000001);
      @(negedge mclk); `CHK("irq_on", 1'b1, irq)
      sw_wr(CTL_IRQ_EN, 32'h00000000);
      @(negedge mclk); `CHK("irq_masked", 1'b0, irq)
      sw_wr(CTL_IRQ_EN, 32'h00000001);
      ev_chk({1'b1, EV_RESTART});
      sw_wr(CTL_IRQ_CLR, 32'h00000001);
      @(negedge mclk); `CHK("irq_cleared", 1'b0, irq)
   endtask : t_restart
   task t_defaults;
      logic [15:0] exp [3];
      exp = '{16'h0055, 16'h0055, 16'h0300};
      for (int i = 0; i < 3; i++) begin
         link_op(1'b0, 4'h0, 8'(i), 16'h0000);
         `CHK("mask_reset", exp[i], rd[15:0])
      end
      step(4'h1, 4'h0, 5'h00, {1'b1, 6'h01});
      step(4'h0, 4'h0, 5'h00, 7'h00);
      step(4'h0, 4'h1, 5'h00, {1'b1, 6'h03});
      step(4'h0, 4'h0, 5'h00, 7'h00);
      step(4'h0, 4'h0, 5'h01, 7'h00);
      step(4'h0, 4'h0, 5'h00, 7'h00);
      step(4'h0, 4'h0, 5'h10, {1'b1, 6'h19});
      step(4'h0, 4'h0, 5'h00, {1'b1, 6'h1a});
   endtask : t_defaults
   task t_all_events;
      logic [5:0] c;
      link_op(1'b1, 4'h0, ITEM_OC_MASK, 16'h00ff);
      link_op(1'b1, 4'h0, ITEM_EF_MASK, 16'h00ff);
      link_op(1'b1, 4'h0, ITEM_OUT_MASK, 16'h03ff);
      link_op(1'b0, 4'h0, ITEM_OUT_MASK, 16'h0000);
      `CHK("out_mask", 16'h03ff, rd[15:0])
      for (int s = 0; s < 4; s++) begin
         c = (s < 2 ? 6'h01 : 6'h09) + 6'(4 * (s % 2));
         step(4'(1 << s), 4'h0, 5'h00, {1'b1, c});
         step(4'h0, 4'h0, 5'h00, {1'b1, c + 6'h01});
         step(4'h0, 4'(1 << s), 5'h00, {1'b1, c + 6'h02});
         step(4'h0, 4'h0, 5'h00, {1'b1, c + 6'h03});
      end
      for (int k = 0; k < 5; k++) begin
         c = 6'h11 + 6'(2 * k);
         step(4'h0, 4'h0, 5'(1 << k), {1'b1, c});
         step(4'h0, 4'h0, 5'h00, {1'b1, c + 6'h01});
      end
      // Only low-set operate left enabled
      link_op(1'b1, 4'h0, ITEM_OC_MASK, 16'h0004);
      step(4'h1, 4'h0, 5'h00, 7'h00);
      step(4'h1, 4'h1, 5'h00, {1'b1, 6'h03});
      step(4'h0, 4'h0, 5'h00, 7'h00);
   endtask : t_all_events
   task t_items;
      @(posedge mclk); input_value <= 16'hbeef;
      link_op(1'b0, 4'h1, ITEM_INPUTS, 16'h0000);
      `CHK("off_channel", 1'b1, st[IRQ_REFUSED])
      link_op(1'b0, 4'h0, 8'h08, 16'h0000);
      `CHK("bad_item", 1'b1, st[IRQ_REFUSED])
      link_op(1'b0, 4'h0, ITEM_INPUTS, 16'h0000);
      `CHK("inputs", 16'hbeef, rd[15:0])
      link_op(1'b1, 4'h0, ITEM_OUTPUTS, 16'h0011);
      `CHK("locked", 1'b1, st[IRQ_REFUSED])
      `CHK("force_kept", 5'h00, out_force)
      link_op(1'b1, 4'h0, ITEM_PASSWORD, PASSWORD_VALUE);
      link_op(1'b1, 4'h0, ITEM_OUTPUTS, 16'h0011);
      `CHK("unlocked", 1'b0, st[IRQ_REFUSED])
      `CHK("force_set", 5'h11, out_force)
      link_op(1'b0, 4'h0, ITEM_MEMORY, 16'h0000);
      `CHK("memory", 16'h00ff, rd[15:0])
      link_op(1'b1, 4'h0, ITEM_MEMORY, 16'h0000);
      link_op(1'b0, 4'h0, ITEM_MEMORY, 16'h0000);
      `CHK("memory_clear", 16'h0000, rd[15:0])
   endtask : t_items
   // One record held by the unit, sixteen queued, the rest overflow
   task t_overflow;
      for (int i = 0; i < 20; i++) begin
         @(posedge mclk);
         stage_start <= 4'(4 * ((i + 1) % 2));
         @(posedge mclk);
      end
      for (int j = 0; j < 17; j++) begin
         ev_chk({1'b1, 6'(9 + j % 2)});
      end
      ev_chk({1'b1, EV_OVERFLOW});
   endtask : t_overflow
   // ****************************************
   // Run control
   // ****************************************
   task wrap_up;
      if (errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      reset = 1'b1; wr_s = 1'b0; rd_s = 1'b0; addr = 4'h0;
      wdata = '0; stage_start = 4'h0; stage_operate = 4'h0;
      out_signal = 5'h00; input_value = 16'h0000;
      errors = 0; tests_run = 0;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      t_restart;
      t_defaults;
      t_all_events;
      t_items;
      t_overflow;
      wrap_up;
   end
   // Far above the thousand or so cycles the scenarios need
   initial begin
      repeat (30000) @(posedge mclk);
      errors++;
      wrap_up;
   end
endmodule : test_protection_event_mask_reporter
